// file: hw/apf_device.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// - Start muted; play only after de-mute command.
// - Host selects bit or master clock ratio.
// - Bit clock: 32 edges, carrier 8x frame.
// - Master clock: 8 edges, carrier 8x frame.
// - Reset low restores all defaults.
// - Leave reset on 512th cycle after release.
// - Power-down low fades volume over frames.
// - Stages off only after fade completes.
// - Host waits fade time before assuming down.
// - No register writes while powered down.
// - Registers retained through power-down.
// - Early power-down release fades back in.
// - Over-temperature disables stages until cleared.
// - Temp or short latches fault, pin low.
// - Fault cleared by reset, power-down, mute.
// - Digital supply low disables stages.
// - Speaker over-voltage disables stages.
// - Speaker under-voltage disables stages.
// - Fault pin strap picks bus address.
// - Mono-select pin sets output configuration.
// - Sequencing signals suppress pops.
// - Mono-select low stereo, high mono.
// - Ratio strap loads multiplier field at release.
module apf_device #(
    parameter int unsigned RESET_EXIT = apf_pkg::RESET_EXIT_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    apf_if.device link,
    input wire logic i_mono_select,
    input wire logic i_ratio_strap,
    input wire logic i_over_temp,
    input wire logic i_short,
    input wire logic i_digital_supply_low,
    input wire logic i_speaker_supply_over,
    input wire logic i_speaker_supply_under,
    output logic o_stage_en,
    output logic o_clocks_en,
    output logic o_bias_en,
    output logic o_mono,
    output logic [4:0] o_atten,
    output logic [3:0] o_pll_multiplier_field,
    output logic [5:0] o_edge_eval,
    output logic [3:0] o_carrier_per_frame,
    output logic [6:0] o_bus_addr
);
    apf_pkg::apf_state_t state_q;
    logic [9:0] exit_cnt_q;
    logic rst_n_prev_q;
    logic frame_prev_q;
    logic demuted_q;
    logic ratio_src_q;
    logic fault_q;
    logic stage_block;
    logic frame_tick;
    logic addr_hit;
    logic fault_clear;

    assign frame_tick = link.frame_clock & ~frame_prev_q;
    // Writes are refused while powered down or held in reset
    assign addr_hit = link.bus_wr && link.bus_addr == o_bus_addr && state_q != apf_pkg::APF_RESET
        && state_q != apf_pkg::APF_POWER_DOWN;
    assign fault_clear = !link.reset_n || !link.power_down_n || (addr_hit && link.bus_mute);
    // Supply conditions gate the stages level-sensitively; over-temperature and short also latch fault_q, which holds the stages off until cleared
    assign stage_block = i_over_temp | i_digital_supply_low | i_speaker_supply_over
        | i_speaker_supply_under | fault_q;

    // Edge history for frame clock and reset pin
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            frame_prev_q <= 1'b0;
            rst_n_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            frame_prev_q <= link.frame_clock;
            rst_n_prev_q <= link.reset_n;
        end
    end

    // Straps caught at the reset pin's rising edge, never in the async path
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_bus_addr <= apf_pkg::ADDR_STRAP_LOW;
            o_pll_multiplier_field <= apf_pkg::MULT_RATIO_SIXTEEN;
        end else if (i_clk_en && link.reset_n && !rst_n_prev_q) begin
            o_bus_addr <= link.fault_i ? apf_pkg::ADDR_STRAP_HIGH : apf_pkg::ADDR_STRAP_LOW;
            o_pll_multiplier_field <= i_ratio_strap ? apf_pkg::MULT_RATIO_ONE
                : apf_pkg::MULT_RATIO_SIXTEEN;
        end
    end

    // Configuration registers: defaults under reset pin, kept through power-down
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            demuted_q <= 1'b0;
            ratio_src_q <= apf_pkg::RATIO_SRC_BIT;
        end else if (i_clk_en) begin
            if (!link.reset_n) begin
                demuted_q <= 1'b0;
                ratio_src_q <= apf_pkg::RATIO_SRC_BIT;
            end else if (addr_hit) begin
                if (link.bus_demute)
                    demuted_q <= 1'b1;
                if (link.bus_mute)
                    demuted_q <= 1'b0;
                ratio_src_q <= link.bus_ratio_src;
            end
        end // Nothing here depends on power-down, so settings persist
    end

    // Multiplier evaluation factor from chosen ratio; carrier is 8x frame either way
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_edge_eval <= apf_pkg::EDGE_EVAL_BIT;
            o_carrier_per_frame <= apf_pkg::CARRIER_PER_FRAME;
        end else if (i_clk_en) begin
            o_edge_eval <= (ratio_src_q == apf_pkg::RATIO_SRC_MASTER) ? apf_pkg::EDGE_EVAL_MASTER
                : apf_pkg::EDGE_EVAL_BIT;
            o_carrier_per_frame <= apf_pkg::CARRIER_PER_FRAME;
        end
    end

    // Latched fault: set wins over clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            fault_q <= 1'b0;
        end else if (i_clk_en) begin
            if (i_over_temp || i_short)
                fault_q <= 1'b1;
            else if (fault_clear)
                fault_q <= 1'b0;
        end
    end

    // Main sequencer: reset exit, mute, fade, power-down
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_q <= apf_pkg::APF_RESET;
            exit_cnt_q <= 10'h000;
            o_atten <= apf_pkg::FADE_FULL;
        end else if (i_clk_en) begin
            if (!link.reset_n) begin
                state_q <= apf_pkg::APF_RESET;
                exit_cnt_q <= 10'h000;
                o_atten <= apf_pkg::FADE_FULL;
            end else begin
                case (state_q)
                    apf_pkg::APF_RESET: begin
                        exit_cnt_q <= exit_cnt_q + 10'h001;
                        if (exit_cnt_q == 10'(RESET_EXIT - 1))
                            state_q <= apf_pkg::APF_MUTED;
                    end
                    apf_pkg::APF_MUTED: begin
                        o_atten <= apf_pkg::FADE_FULL;
                        if (!link.power_down_n)
                            state_q <= apf_pkg::APF_POWER_DOWN;
                        else if (demuted_q)
                            state_q <= apf_pkg::APF_FADE_IN;
                    end
                    apf_pkg::APF_FADE_IN: begin
                        if (!link.power_down_n) begin
                            state_q <= apf_pkg::APF_FADE_OUT;
                        end else if (!demuted_q) begin
                            state_q <= apf_pkg::APF_FADE_OUT;
                        end else if (frame_tick) begin
                            if (o_atten == apf_pkg::FADE_NONE)
                                state_q <= apf_pkg::APF_PLAY;
                            else
                                o_atten <= o_atten - 5'h01;
                        end
                    end
                    apf_pkg::APF_PLAY: begin
                        if (!link.power_down_n || !demuted_q)
                            state_q <= apf_pkg::APF_FADE_OUT;
                    end
                    apf_pkg::APF_FADE_OUT: begin
                        if (link.power_down_n && demuted_q) begin
                            state_q <= apf_pkg::APF_FADE_IN;
                        end else if (frame_tick) begin
                            if (o_atten == apf_pkg::FADE_FULL)
                                state_q <= link.power_down_n ? apf_pkg::APF_MUTED
                                    : apf_pkg::APF_POWER_DOWN;
                            else
                                o_atten <= o_atten + 5'h01;
                        end
                    end
                    apf_pkg::APF_POWER_DOWN: begin
                        o_atten <= apf_pkg::FADE_FULL;
                        if (link.power_down_n)
                            state_q <= demuted_q ? apf_pkg::APF_FADE_IN : apf_pkg::APF_MUTED;
                    end
                    default: state_q <= apf_pkg::APF_RESET;
                endcase
            end
        end
    end

    // Registered outputs derived from state, protection levels, the mono-select pin and the bus address match
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_stage_en <= 1'b0;
            o_clocks_en <= 1'b0;
            o_bias_en <= 1'b0;
            o_mono <= 1'b0;
            link.fault_dev_oe <= 1'b0;
            link.bus_ack <= 1'b0;
            link.powered_down <= 1'b0;
        end else if (i_clk_en) begin
            o_stage_en <= !stage_block && (state_q == apf_pkg::APF_FADE_IN
                || state_q == apf_pkg::APF_PLAY || state_q == apf_pkg::APF_FADE_OUT);
            o_clocks_en <= state_q != apf_pkg::APF_POWER_DOWN;
            o_bias_en <= state_q != apf_pkg::APF_POWER_DOWN && state_q != apf_pkg::APF_RESET;
            o_mono <= i_mono_select;
            link.fault_dev_oe <= fault_q;
            link.bus_ack <= addr_hit;
            link.powered_down <= state_q == apf_pkg::APF_POWER_DOWN;
        end
    end
endmodule : apf_device

// file: hw/apf_host.sv
`timescale 1ns/1ns
// Host end: drives pins and issues bus commands from a simple command port
module apf_host #(
    parameter int unsigned FADE_WAIT = 32'h00030d40
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    apf_if.host link,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_frame_clock,
    input wire logic i_addr_strap,
    output logic [7:0] o_rdata
);
    logic [7:0] ctrl_q;
    logic [31:0] wait_q;
    logic pd_prev_q;
    logic down_known_q;

    // Control register drives pins; bus command pulses one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            ctrl_q <= 8'h00;
            link.bus_wr <= 1'b0;
            link.bus_demute <= 1'b0;
            link.bus_mute <= 1'b0;
            link.bus_ratio_src <= 1'b0;
            link.bus_addr <= apf_pkg::ADDR_STRAP_LOW;
        end else if (i_clk_en) begin
            link.bus_wr <= 1'b0;
            link.bus_addr <= i_addr_strap ? apf_pkg::ADDR_STRAP_HIGH : apf_pkg::ADDR_STRAP_LOW;
            if (i_wr && i_addr == apf_pkg::HREG_CTRL)
                ctrl_q <= i_wdata;
            // Writes held off while the reset pin is held low or the device reports powered_down
            if (i_wr && i_addr == apf_pkg::HREG_CMD && ctrl_q[apf_pkg::HC_PWR_UP]
                && !link.powered_down) begin
                link.bus_wr <= 1'b1;
                link.bus_demute <= i_wdata[apf_pkg::HC_RUN];
                link.bus_mute <= i_wdata[apf_pkg::HC_MUTE];
                link.bus_ratio_src <= i_wdata[apf_pkg::HC_RATIO_SRC];
            end
        end
    end

    // Pins: reset and power-down from control bits, strap on fault pin during reset
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            link.reset_n <= 1'b0;
            link.power_down_n <= 1'b0;
            link.frame_clock <= 1'b0;
            link.fault_host_oe <= 1'b1;
            link.fault_host_o <= 1'b0;
        end else if (i_clk_en) begin
            link.reset_n <= ctrl_q[apf_pkg::HC_PWR_UP];
            link.power_down_n <= ctrl_q[apf_pkg::HC_RUN];
            link.frame_clock <= i_frame_clock;
            // Strap stays on one cycle past the reset pin's rise, so the device still sees it
            link.fault_host_oe <= !ctrl_q[apf_pkg::HC_PWR_UP] || !link.reset_n;
            link.fault_host_o <= i_addr_strap;
        end
    end

    // Fade wait after lowering power-down before treating device as down
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wait_q <= 32'h0;
            pd_prev_q <= 1'b0;
            down_known_q <= 1'b0;
        end else if (i_clk_en) begin
            pd_prev_q <= link.power_down_n;
            if (link.power_down_n) begin
                down_known_q <= 1'b0;
                wait_q <= 32'h0;
            end else if (pd_prev_q) begin
                wait_q <= FADE_WAIT;
            end else if (wait_q != 32'h0) begin
                wait_q <= wait_q - 32'h1;
            end else begin
                down_known_q <= 1'b1;
            end
        end
    end

    // Read port: data one cycle after strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_clk_en && i_rd) begin
            case (i_addr)
                apf_pkg::HREG_CTRL: o_rdata <= ctrl_q;
                apf_pkg::HREG_STATUS: o_rdata <= {5'h00, down_known_q, link.powered_down,
                    !link.fault_i};
                default: o_rdata <= 8'h00;
            endcase
        end
    end
endmodule : apf_host

// file: pkg/apf_if.sv
`timescale 1ns/1ns
interface apf_if;
    logic reset_n;
    logic power_down_n;
    logic frame_clock;
    // Open-drain fault pin: device drives low, host may drive strap
    logic fault_dev_oe;
    logic fault_host_oe;
    logic fault_host_o;
    logic fault_i;
    // Simplified control-bus word channel
    logic bus_wr;
    logic [6:0] bus_addr;
    logic bus_demute;
    logic bus_mute;
    logic bus_ratio_src;
    logic bus_ack;
    logic powered_down;
    logic fault_n_view;

    // Wire level: pulled high unless someone drives
    assign fault_i = fault_dev_oe ? 1'b0 : (fault_host_oe ? fault_host_o : 1'b1);

    modport device (
        input reset_n, power_down_n, frame_clock, fault_i,
        input bus_wr, bus_addr, bus_demute, bus_mute, bus_ratio_src,
        output fault_dev_oe, bus_ack, powered_down
    );
    modport host (
        output reset_n, power_down_n, frame_clock, fault_host_oe, fault_host_o,
        output bus_wr, bus_addr, bus_demute, bus_mute, bus_ratio_src,
        input fault_i, bus_ack, powered_down
    );
endinterface : apf_if

// file: pkg/apf_pkg.sv
package apf_pkg;
    // Sequencer timing (cycles of i_clk_sys at 20 MHz)
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned RESET_EXIT_CYCLES = 512;
    localparam logic [9:0] RESET_EXIT_LAST = 10'h1ff;
    // Volume attenuation steps for a full fade (one step per frame)
    localparam int unsigned FADE_STEPS = 16;
    localparam logic [4:0] FADE_FULL = 5'h10;
    localparam logic [4:0] FADE_NONE = 5'h00;
    // Bus addresses selected by the fault-pin strap
    localparam logic [6:0] ADDR_STRAP_LOW = 7'h30;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h31;
    // Multiplier field defaults selected by the ratio strap
    localparam logic [3:0] MULT_RATIO_ONE = 4'h0;
    localparam logic [3:0] MULT_RATIO_SIXTEEN = 4'h1;
    // Clock ratio selection and edge-evaluation factors
    localparam logic RATIO_SRC_BIT = 1'b0;
    localparam logic RATIO_SRC_MASTER = 1'b1;
    localparam logic [5:0] EDGE_EVAL_BIT = 6'h20;
    localparam logic [5:0] EDGE_EVAL_MASTER = 6'h08;
    localparam logic [3:0] CARRIER_PER_FRAME = 4'h8;
    // Host command register offsets
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_CMD = 4'h1;
    localparam logic [3:0] HREG_STATUS = 4'h2;
    // Host control register and command word bit positions
    localparam int unsigned HC_PWR_UP = 0;
    localparam int unsigned HC_RUN = 1;
    localparam int unsigned HC_MUTE = 2;
    localparam int unsigned HC_RATIO_SRC = 3;
    // Sequencer states
    typedef enum logic [5:0] {
        APF_RESET = 6'h01,
        APF_MUTED = 6'h02,
        APF_FADE_IN = 6'h04,
        APF_PLAY = 6'h08,
        APF_FADE_OUT = 6'h10,
        APF_POWER_DOWN = 6'h20
    } apf_state_t;
endpackage : apf_pkg

// file: verification/apf_assertions.sv
`timescale 1ns/1ns
// Watches the link between the host end and the device end
module apf_assertions #(
    parameter int unsigned RESET_EXIT = 512
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic fault_dev_oe,
    input wire logic fault_i,
    input wire logic bus_wr,
    input wire logic [6:0] bus_addr,
    input wire logic bus_mute,
    input wire logic bus_demute,
    input wire logic bus_ack,
    input wire logic powered_down
);
    logic [10:0] up_cnt_q;
    logic rst_seen_q;
    logic strap_q;

    // Cycles since the reset pin rose; saturates so it never wraps into the early window
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !reset_n) begin
            up_cnt_q <= 11'h000;
        end else if (up_cnt_q != 11'h7ff) begin
            up_cnt_q <= up_cnt_q + 11'h001;
        end
    end

    // Strap level on the fault wire at the reset pin's rising edge
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rst_seen_q <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            rst_seen_q <= reset_n;
            if (reset_n && !rst_seen_q) begin
                strap_q <= fault_i;
            end
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // A small margin around the exit count keeps the check off the exact edge
    ack_after_wr_a: assert property (bus_ack |-> $past(bus_wr))
        else $error("ack without a preceding command");
    early_no_ack_a: assert property (bus_wr && up_cnt_q < RESET_EXIT - 4 |=> !bus_ack)
        else $error("command answered while still in reset");
    match_ack_a: assert property (bus_wr && reset_n && !powered_down
        && up_cnt_q > RESET_EXIT + 4 && bus_addr == {6'h18, strap_q} |=> bus_ack)
        else $error("command to own address not answered");
    other_addr_a: assert property (bus_wr && bus_addr != {6'h18, strap_q} |=> !bus_ack)
        else $error("command to other address answered");
    down_no_ack_a: assert property (bus_wr && powered_down |=> !bus_ack)
        else $error("command answered while powered down");
    fault_hold_a: assert property (fault_dev_oe && reset_n && power_down_n && !bus_wr
        && !$past(bus_wr && bus_mute) |=> fault_dev_oe)
        else $error("fault released without a clearing event");
    fault_clear_a: assert property ((!reset_n || !power_down_n) [*3] |-> !fault_dev_oe)
        else $error("fault still driven during reset or power-down");
    down_needs_pd_a: assert property ($rose(powered_down) |-> !power_down_n
        && !$past(power_down_n, 16))
        else $error("powered down without a long enough power-down request");

    cover property (bus_wr && bus_demute ##1 bus_ack);
    cover property ($rose(powered_down));
    cover property ($rose(fault_dev_oe));
endmodule : apf_assertions

// file: verification/tb_amp_power_fault_sequencer.sv
`timescale 1ns/1ns
module tb_amp_power_fault_sequencer;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fclk = 1'b0, astrap = 1'b1;
    logic mono = 1'b0, rstrap = 1'b1, temp = 1'b0, shrt = 1'b0, stage, clks, bias, omono;
    logic [2:0] sup = 3'h0;
    logic [3:0] addr = 4'h0, pll, carrier;
    logic [7:0] wdata = 8'h00, rdata, d;
    logic [4:0] atten;
    logic [5:0] edge_eval;
    logic [6:0] baddr;
    int mismatches = 0, checks = 0, cycles = 0;

    apf_if link_if();
    apf_host #(.FADE_WAIT(220)) apf_host_inst (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_clk_en(1'b1), .link(link_if), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .i_frame_clock(fclk), .i_addr_strap(astrap), .o_rdata(rdata));
    apf_device #(.RESET_EXIT(512)) apf_device_inst (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_clk_en(1'b1), .link(link_if), .i_mono_select(mono), .i_ratio_strap(rstrap),
        .i_over_temp(temp), .i_short(shrt), .i_digital_supply_low(sup[0]),
        .i_speaker_supply_over(sup[1]), .i_speaker_supply_under(sup[2]),
        .o_stage_en(stage), .o_clocks_en(clks), .o_bias_en(bias), .o_mono(omono),
        .o_atten(atten), .o_pll_multiplier_field(pll), .o_edge_eval(edge_eval),
        .o_carrier_per_frame(carrier), .o_bus_addr(baddr));
    apf_assertions #(.RESET_EXIT(512)) apf_assertions_inst (.i_clk_sys(clk),
        .i_sys_rst(rst), .reset_n(link_if.reset_n), .power_down_n(link_if.power_down_n),
        .fault_dev_oe(link_if.fault_dev_oe), .fault_i(link_if.fault_i),
        .bus_wr(link_if.bus_wr), .bus_addr(link_if.bus_addr), .bus_mute(link_if.bus_mute),
        .bus_demute(link_if.bus_demute), .bus_ack(link_if.bus_ack),
        .powered_down(link_if.powered_down));

    // 20 MHz clock
    always #25 clk = ~clk;

    // Hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w

    // One strobe cycle on the command port
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data are taken in the one cycle after the strobe
    task automatic rd_stat();
        @(posedge clk);
        addr <= apf_pkg::HREG_STATUS;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd_stat

    // Frame edges spaced wide enough for any input synchroniser
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge clk);
            fclk <= 1'b1;
            w(6);
            fclk <= 1'b0;
            w(6);
        end
    endtask : frames

    task automatic t_reset();
        w(5);
        rst <= 1'b0;
        w(2);
        chk(8'(atten), 8'(apf_pkg::FADE_FULL));
        chk(8'(stage), 8'h00);
        chk(8'(baddr), 8'(apf_pkg::ADDR_STRAP_LOW));
        chk(8'(pll), 8'(apf_pkg::MULT_RATIO_SIXTEEN));
        chk(8'(edge_eval), 8'(apf_pkg::EDGE_EVAL_BIT));
    endtask : t_reset

    // Early de-mute is dropped; straps are taken when reset rises
    task automatic t_exit();
        wr_reg(apf_pkg::HREG_CTRL, 8'h03);
        w(20);
        wr_reg(apf_pkg::HREG_CMD, 8'h02);
        frames(2);
        chk(8'(atten), 8'(apf_pkg::FADE_FULL));
        w(600);
        chk(8'(atten), 8'(apf_pkg::FADE_FULL));
        chk(8'(baddr), 8'(apf_pkg::ADDR_STRAP_HIGH));
        chk(8'(pll), 8'(apf_pkg::MULT_RATIO_ONE));
        wr_reg(apf_pkg::HREG_CMD, 8'h02);
        w(4);
        frames(1);
        chk(8'(atten), 8'h0f);
        frames(15);
        chk(8'(atten), 8'(apf_pkg::FADE_NONE));
        chk(8'(stage), 8'h01);
    endtask : t_exit

    task automatic t_ratio_mono();
        wr_reg(apf_pkg::HREG_CMD, 8'h08);
        w(4);
        chk(8'(edge_eval), 8'(apf_pkg::EDGE_EVAL_MASTER));
        chk(8'(carrier), 8'(apf_pkg::CARRIER_PER_FRAME));
        wr_reg(apf_pkg::HREG_CMD, 8'h00);
        w(4);
        chk(8'(edge_eval), 8'(apf_pkg::EDGE_EVAL_BIT));
        chk(8'(carrier), 8'(apf_pkg::CARRIER_PER_FRAME));
        for (int i = 1; i >= 0; i--) begin
            mono <= 1'(i);
            w(4);
            chk(8'(omono), 8'(i));
        end
    endtask : t_ratio_mono

    // Supply events stop the stages only while they last
    task automatic t_supply();
        for (int i = 0; i < 3; i++) begin
            sup <= 3'h1 << i;
            w(4);
            chk(8'(stage), 8'h00);
            sup <= 3'h0;
            w(4);
            chk(8'(stage), 8'h01);
        end
    endtask : t_supply

    task automatic t_pd();
        shrt <= 1'b1;
        w(2);
        shrt <= 1'b0;
        w(4);
        rd_stat();
        chk({7'h00, d[0]}, 8'h01);
        chk(8'(stage), 8'h00);
        wr_reg(apf_pkg::HREG_CTRL, 8'h01);
        w(3);
        rd_stat();
        chk({7'h00, d[0]}, 8'h00);
        chk({7'h00, d[2]}, 8'h00);
        frames(8);
        chk(8'(atten), 8'h08);
        rd_stat();
        chk({7'h00, d[1]}, 8'h00);
        wr_reg(apf_pkg::HREG_CTRL, 8'h03);
        w(4);
        frames(8);
        chk(8'(atten), 8'(apf_pkg::FADE_NONE));
        chk({6'h00, clks, bias}, 8'h03);
        wr_reg(apf_pkg::HREG_CTRL, 8'h01);
        frames(17);
        w(4);
        chk(8'(atten), 8'(apf_pkg::FADE_FULL));
        chk({5'h00, stage, clks, bias}, 8'h00);
        rd_stat();
        chk({7'h00, d[1]}, 8'h01);
        chk({7'h00, d[2]}, 8'h01);
        wr_reg(apf_pkg::HREG_CMD, 8'h08);
        w(4);
        chk(8'(edge_eval), 8'(apf_pkg::EDGE_EVAL_BIT));
        wr_reg(apf_pkg::HREG_CTRL, 8'h03);
        w(8);
        rd_stat();
        chk({7'h00, d[1]}, 8'h00);
        chk(8'(pll), 8'(apf_pkg::MULT_RATIO_ONE));
        chk(8'(clks), 8'h01);
    endtask : t_pd

    // Heat latches the fault; only a mute command lets it go here
    task automatic t_temp();
        temp <= 1'b1;
        w(4);
        chk(8'(stage), 8'h00);
        chk(8'(link_if.fault_i), 8'h00);
        temp <= 1'b0;
        w(4);
        rd_stat();
        chk({7'h00, d[0]}, 8'h01);
        wr_reg(apf_pkg::HREG_CMD, 8'h04);
        w(4);
        rd_stat();
        chk({7'h00, d[0]}, 8'h00);
    endtask : t_temp

    // Reset pin drops the de-mute and re-reads both straps, here at their low levels
    task automatic t_pin_reset();
        wr_reg(apf_pkg::HREG_CMD, 8'h02);
        wr_reg(apf_pkg::HREG_CTRL, 8'h00);
        w(4);
        chk(8'(atten), 8'(apf_pkg::FADE_FULL));
        astrap <= 1'b0;
        rstrap <= 1'b0;
        wr_reg(apf_pkg::HREG_CTRL, 8'h03);
        w(530);
        chk(8'(baddr), 8'(apf_pkg::ADDR_STRAP_LOW));
        chk(8'(pll), 8'(apf_pkg::MULT_RATIO_SIXTEEN));
        frames(1);
        chk(8'(atten), 8'(apf_pkg::FADE_FULL));
        wr_reg(apf_pkg::HREG_CMD, 8'h02);
        w(4);
        frames(1);
        chk(8'(atten), 8'h0f);
    endtask : t_pin_reset

    initial begin
        t_reset();
        t_exit();
        t_ratio_mono();
        t_supply();
        t_pd();
        t_temp();
        t_pin_reset();
        test_done();
    end
endmodule : tb_amp_power_fault_sequencer
